// ==== rtl/cfrl_controller.sv ====
// Function
// - auto restart: release status within 40 us
// - bridge JTAG onto four flash pins
// - loader image enters user mode despite done low
`timescale 1ns/1ps
`default_nettype none
module cfrl_controller (
    input wire logic clk,
    input wire logic rst,
    input wire logic auto_restart_strap,
    input wire logic [1:0] config_mode_select,
    input wire logic loader_image,
    input wire logic config_error,
    input wire logic config_request_n,
    input wire logic config_done_line,
    input wire logic config_status_n_in,
    output logic config_status_n_out,
    output logic config_status_n_oe,
    output logic user_mode,
    output logic bridge_enable,
    input wire logic jtag_clk,
    input wire logic jtag_shift,
    input wire logic jtag_tdi,
    output logic jtag_tdo,
    output logic serial_config_clock,
    input wire logic flash_data_in,
    output logic active_serial_data_out,
    output logic flash_select_n
);
    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [cfrl_pkg::SYNC_STAGES-1:0] req_sync_q, req_sync_d;
    logic [cfrl_pkg::SYNC_STAGES-1:0] done_sync_q, done_sync_d;
    logic req_n_q, req_n_d, done_q, done_d;

    // accept a change once the last two stages agree
    function automatic logic sync_filter(input logic [cfrl_pkg::SYNC_STAGES-1:0] s,
                                         input logic held);
        sync_filter = (s[1] == s[2]) ? s[2] : held;
    endfunction : sync_filter

    always_comb begin
        req_sync_d = {req_sync_q[1:0], config_request_n};
        done_sync_d = {done_sync_q[1:0], config_done_line};
        req_n_d = sync_filter(req_sync_q, req_n_q);
        done_d = sync_filter(done_sync_q, done_q);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_sync_q <= 3'h7;
            done_sync_q <= 3'h0;
            req_n_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            req_sync_q <= req_sync_d;
            done_sync_q <= done_sync_d;
            req_n_q <= req_n_d;
            done_q <= done_d;
        end
    end

    // --------------------------------------------------------------
    // straps caught while reset is held
    // --------------------------------------------------------------
    logic auto_q, auto_d, loader_q, loader_d, as_mode_q, as_mode_d;

    always_comb begin
        auto_d = rst ? auto_restart_strap : auto_q;
        loader_d = rst ? loader_image : loader_q;
        as_mode_d = rst ? ((config_mode_select == cfrl_pkg::MODE_ACTIVE_SERIAL) ||
                           (config_mode_select == cfrl_pkg::MODE_FAST_ACTIVE_SERIAL))
                        : as_mode_q;
    end

    always_ff @(posedge clk) begin
        auto_q <= auto_d;
        loader_q <= loader_d;
        as_mode_q <= as_mode_d;
    end

    // --------------------------------------------------------------
    // error, time-out and restart sequencing
    // --------------------------------------------------------------
    cfrl_pkg::cfrl_state_t state_q, state_d;
    logic [cfrl_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic oe_q, oe_d, user_q, user_d, bridge_q, bridge_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            cfrl_pkg::CFRL_ST_CONFIG: begin
                cnt_d = cfrl_pkg::CNT_ZERO;
                if (!req_n_q) begin
                    state_d = cfrl_pkg::CFRL_ST_RESTART;
                end else if (config_error) begin
                    state_d = auto_q ? cfrl_pkg::CFRL_ST_TIMEOUT
                                     : cfrl_pkg::CFRL_ST_HOLD;
                end else if (done_q || loader_q) begin
                    state_d = cfrl_pkg::CFRL_ST_USER;
                end
            end
            cfrl_pkg::CFRL_ST_TIMEOUT: begin
                cnt_d = cnt_q + cfrl_pkg::CNT_ONE;
                if (cnt_q == cfrl_pkg::RESET_TMO_CYC - cfrl_pkg::CNT_ONE) begin
                    state_d = cfrl_pkg::CFRL_ST_CONFIG;  // release, loader restarts
                end
            end
            cfrl_pkg::CFRL_ST_HOLD: begin
                cnt_d = cfrl_pkg::CNT_ZERO;
                if (!req_n_q) begin
                    state_d = cfrl_pkg::CFRL_ST_RESTART;
                end
            end
            cfrl_pkg::CFRL_ST_RESTART: begin
                if (cnt_q != cfrl_pkg::REQ_MIN_CYC) begin
                    cnt_d = cnt_q + cfrl_pkg::CNT_ONE;
                end
                if (req_n_q) begin
                    // too short a pulse is not a restart
                    state_d = (cnt_q == cfrl_pkg::REQ_MIN_CYC) ? cfrl_pkg::CFRL_ST_CONFIG
                                                               : cfrl_pkg::CFRL_ST_HOLD;
                    cnt_d = cfrl_pkg::CNT_ZERO;
                end
            end
            cfrl_pkg::CFRL_ST_USER: begin
                cnt_d = cfrl_pkg::CNT_ZERO;
                if (!req_n_q) begin
                    state_d = cfrl_pkg::CFRL_ST_RESTART;
                end
            end
            default: begin
                state_d = cfrl_pkg::CFRL_ST_CONFIG;
                cnt_d = cfrl_pkg::CNT_ZERO;
            end
        endcase
        // status pin driven low whenever not released
        oe_d = (state_d == cfrl_pkg::CFRL_ST_TIMEOUT) || (state_d == cfrl_pkg::CFRL_ST_HOLD) ||
               (state_d == cfrl_pkg::CFRL_ST_RESTART);
        user_d = (state_d == cfrl_pkg::CFRL_ST_USER);
        // bridge only once the loader image runs in user mode
        bridge_d = user_d && loader_q && as_mode_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= cfrl_pkg::CFRL_ST_CONFIG;
            cnt_q <= cfrl_pkg::CNT_ZERO;
            oe_q <= 1'b0;
            user_q <= 1'b0;
            bridge_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            oe_q <= oe_d;
            user_q <= user_d;
            bridge_q <= bridge_d;
        end
    end

    // open-drain status: only ever drives low
    always_comb begin
        config_status_n_out = 1'b0;
        config_status_n_oe = oe_q;
        user_mode = user_q;
        bridge_enable = bridge_q;
    end

    // --------------------------------------------------------------
    // flash pin bridge on the JTAG clock
    // --------------------------------------------------------------
    cfrl_flash_bridge u_bridge (
        .jtag_clk(jtag_clk),
        .bridge_en_async(bridge_q),
        .jtag_shift(jtag_shift),
        .jtag_tdi(jtag_tdi),
        .jtag_tdo(jtag_tdo),
        .serial_config_clock(serial_config_clock),
        .flash_data_in(flash_data_in),
        .active_serial_data_out(active_serial_data_out),
        .flash_select_n(flash_select_n)
    );

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_auto_release: assert property (
        (state_q == cfrl_pkg::CFRL_ST_TIMEOUT &&
         cnt_q == cfrl_pkg::RESET_TMO_CYC - cfrl_pkg::CNT_ONE) |=> !config_status_n_oe)
        else $error("status not released at time-out end");
    chk_timeout_bound: assert property (
        (state_q == cfrl_pkg::CFRL_ST_TIMEOUT) |-> cnt_q < cfrl_pkg::RESET_TMO_CYC)
        else $error("reset time-out overran");
    chk_error_enter: assert property (
        (state_q == cfrl_pkg::CFRL_ST_CONFIG && req_n_q && config_error && auto_q)
        |=> config_status_n_oe ##1 config_status_n_oe)
        else $error("auto error did not hold status low");
    chk_manual_hold: assert property (
        (state_q == cfrl_pkg::CFRL_ST_HOLD && req_n_q) |=> config_status_n_oe && !user_mode)
        else $error("manual error hold released early");
    chk_short_pulse: assert property (
        (state_q == cfrl_pkg::CFRL_ST_RESTART && req_n_q && cnt_q != cfrl_pkg::REQ_MIN_CYC)
        |=> state_q == cfrl_pkg::CFRL_ST_HOLD)
        else $error("short restart pulse accepted");
    chk_loader_user: assert property (
        (state_q == cfrl_pkg::CFRL_ST_CONFIG && req_n_q && !config_error && loader_q)
        |=> user_mode)
        else $error("loader image kept out of user mode");
    chk_bridge_gate: assert property (
        bridge_enable |-> user_mode && loader_q && as_mode_q)
        else $error("bridge enabled outside loader stage");
    chk_status_drive: assert property (
        $rose(config_status_n_oe) |-> !config_status_n_out && !user_mode)
        else $error("status driven high or in user mode");
    // the wire itself must read low while the device pulls it
    chk_status_pin: assert property (
        config_status_n_oe |-> !config_status_n_in)
        else $error("status wire high while pulled low");
endmodule : cfrl_controller
`default_nettype wire

// ==== rtl/cfrl_flash_bridge.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfrl_flash_bridge (
    input wire logic jtag_clk,
    input wire logic bridge_en_async,
    input wire logic jtag_shift,
    input wire logic jtag_tdi,
    output logic jtag_tdo,
    output logic serial_config_clock,
    input wire logic flash_data_in,
    output logic active_serial_data_out,
    output logic flash_select_n
);
    // --------------------------------------------------------------
    // enable crossing from the core clock
    // --------------------------------------------------------------
    logic en_s1_q, en_s2_q, en_s1_d, en_s2_d;
    logic sclk_q, sclk_d, sel_n_q, sel_n_d, dout_q, dout_d, tdo_q, tdo_d;
    logic active;

    // two-flop level synchroniser; first flop feeds only the second
    always_comb begin
        en_s1_d = bridge_en_async;
        en_s2_d = en_s1_q;
    end

    // pin sequencing: clock divided by two, data moved on the falling phase
    always_comb begin
        active = en_s2_q & jtag_shift;
        sel_n_d = ~active;
        sclk_d = active & ~sclk_q;
        dout_d = (active & sclk_q) ? jtag_tdi : dout_q;
        tdo_d = (active & ~sclk_q) ? flash_data_in : tdo_q;
    end

    always_ff @(posedge jtag_clk) begin
        en_s1_q <= en_s1_d;
        en_s2_q <= en_s2_d;
        sel_n_q <= sel_n_d;
        sclk_q <= sclk_d;
        dout_q <= dout_d;
        tdo_q <= tdo_d;
    end

    always_comb begin
        serial_config_clock = sclk_q;
        flash_select_n = sel_n_q;
        active_serial_data_out = dout_q;
        jtag_tdo = tdo_q;
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_select_idle: assert property (@(posedge jtag_clk)
        !(en_s2_q && jtag_shift) |=> flash_select_n)
        else $error("flash selected while bridge idle");
    chk_data_follow: assert property (@(posedge jtag_clk)
        (en_s2_q && jtag_shift && sclk_q) |=> active_serial_data_out == $past(jtag_tdi))
        else $error("flash data out did not follow shifted bit");
    chk_clock_gated: assert property (@(posedge jtag_clk)
        serial_config_clock |-> !flash_select_n)
        else $error("flash clock toggles while deselected");
endmodule : cfrl_flash_bridge
`default_nettype wire

// ==== shared/cfrl_pkg.sv ====
`default_nettype none
package cfrl_pkg;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 100;            // core clock rate
    localparam int RESET_TMO_US = 40;        // longest status hold after an error with auto restart
    localparam int REQ_MIN_US = 2;           // shortest accepted restart request
    localparam int CNT_W = 12;
    // longest time: rounded down
    localparam logic [CNT_W-1:0] RESET_TMO_CYC = CNT_W'(RESET_TMO_US * CLK_MHZ);
    // least time: rounded up
    localparam logic [CNT_W-1:0] REQ_MIN_CYC = CNT_W'((REQ_MIN_US * CLK_MHZ * 1000 + 999) / 1000);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    // --------------------------------------------------------------
    // mode select encodings
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_ACTIVE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_FAST_ACTIVE_SERIAL = 2'h1;
    localparam int SYNC_STAGES = 3;
    // --------------------------------------------------------------
    // controller states
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        CFRL_ST_CONFIG,
        CFRL_ST_TIMEOUT,
        CFRL_ST_HOLD,
        CFRL_ST_RESTART,
        CFRL_ST_USER
    } cfrl_state_t;
endpackage : cfrl_pkg
`default_nettype wire

// ==== sim/cfrl_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfrl_flash_model (
    input wire logic serial_config_clock,
    input wire logic active_serial_data_out,
    input wire logic flash_select_n,
    output logic flash_data_in,
    output logic [15:0] rx_q
);
    // ----------------------------------------
    // serial flash far side
    // ----------------------------------------
    // shift in on rising clock while selected
    initial rx_q = 16'h0000;
    always @(posedge serial_config_clock) begin
        if (!flash_select_n) begin
            rx_q <= {rx_q[14:0], active_serial_data_out};
        end
    end
    // deselected output shows the inverse, never a stale value
    assign flash_data_in = flash_select_n ? ~rx_q[15] : rx_q[15];
endmodule : cfrl_flash_model
`default_nettype wire

// ==== sim/test_config_error_restart_and_flash_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_config_error_restart_and_flash_loader;
    logic clk = 1'b0, jclk = 1'b0, rst = 1'b1, auto = 1'b1, loader = 1'b0, err = 1'b0;
    logic req_n = 1'b1, done = 1'b0, shift = 1'b0, tdi = 1'b0, ld_oe_n = 1'b1;
    logic [1:0] msel = 2'h0;
    logic st_out, st_oe, um, ben, tdo, sclk, fdi, asdo, fsel_n, st_line;
    logic [15:0] rx, w;
    int error_cnt = 0, checked = 0, seed = 32'h55EE, n, k;
    // ----------------------------------------
    // clocks, pull-up and instances
    // ----------------------------------------
    initial forever #5 clk = ~clk;
    initial forever #3 jclk = ~jclk; // runs free so bridge flops settle
    assign st_line = (st_oe ? st_out : 1'b1) & ld_oe_n; // pull-up, loader enable wired in
    cfrl_controller cfrl_controller_i (.clk(clk), .rst(rst), .auto_restart_strap(auto),
        .config_mode_select(msel), .loader_image(loader), .config_error(err),
        .config_request_n(req_n), .config_done_line(done), .config_status_n_in(st_line),
        .config_status_n_out(st_out), .config_status_n_oe(st_oe), .user_mode(um),
        .bridge_enable(ben), .jtag_clk(jclk), .jtag_shift(shift), .jtag_tdi(tdi),
        .jtag_tdo(tdo), .serial_config_clock(sclk), .flash_data_in(fdi),
        .active_serial_data_out(asdo), .flash_select_n(fsel_n));
    cfrl_flash_model cfrl_flash_model_i (.serial_config_clock(sclk),
        .active_serial_data_out(asdo), .flash_select_n(fsel_n), .flash_data_in(fdi),
        .rx_q(rx));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wrap_up;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // reset with straps held, six cycles
    task boot(input logic a, input logic [1:0] m, input logic l);
        @(negedge clk);
        rst = 1'b1;
        auto = a;
        msel = m;
        loader = l;
        cyc(6);
        rst = 1'b0;
        cyc(1);
    endtask : boot
    task pulse_err;
        err = 1'b1;
        cyc(1);
        err = 1'b0;
    endtask : pulse_err
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        #300000;
        error_cnt++;
        wrap_up();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        // auto restart: status held exactly the time-out, then released
        boot(1'b1, 2'h0, 1'b0);
        chk(st_oe, 1'b0);
        pulse_err();
        cyc(1);
        chk(st_oe, 1'b1);
        chk(st_line, 1'b0);
        cyc(3998);
        chk(st_oe, 1'b1);
        cyc(1);
        chk(st_oe, 1'b0);
        // manual: held low, short request refused, long request restarts
        boot(1'b0, 2'h0, 1'b0);
        pulse_err();
        cyc(5000);
        chk(st_oe, 1'b1);
        n = 50 + ($unsigned($random(seed)) % 100);
        req_n = 1'b0;
        cyc(n);
        chk(st_oe, 1'b1);
        req_n = 1'b1;
        cyc(10);
        chk(st_oe, 1'b1);
        req_n = 1'b0;
        cyc(250);
        req_n = 1'b1;
        cyc(10);
        chk(st_oe, 1'b0);
        // done line enters user mode; errors there are ignored
        boot(1'b1, 2'h0, 1'b0);
        chk(um, 1'b0);
        done = 1'b1;
        cyc(6);
        chk(um, 1'b1);
        chk(ben, 1'b0);
        pulse_err();
        cyc(2);
        chk(st_oe, 1'b0);
        done = 1'b0;
        // loader far side: enhanced wait 64, older wait 16, error pull, restart
        for (int g = 0; g < 2; g++) begin
            boot(1'b1, 2'h0, 1'b0);
            n = g ? 16 : 64;
            if (g) done = 1'b1;
            k = 0;
            while (k < n && !um) begin
                cyc(1);
                k++;
            end
            if (!um) begin
                ld_oe_n = 1'b0;
                pulse_err();
                chk(st_line, 1'b0);
                ld_oe_n = 1'b1;
                k = 0;
                while (!st_line && k < 5000) begin
                    cyc(1);
                    k++;
                end
                chk(k == cfrl_pkg::RESET_TMO_CYC, 1'b1);
            end
            chk(um, g[0]);
            done = 1'b0;
        end
        // loader image: user mode with done low, bridge only in serial modes
        for (int m = 0; m < 3; m++) begin
            boot(1'b1, m[1:0], 1'b1);
            cyc(2);
            chk(um, 1'b1);
            chk(ben, m < 2);
        end
        shift = 1'b1;
        cyc(5);
        chk(fsel_n, 1'b1);
        shift = 1'b0;
        // bridge loopback of a random word through the flash model
        boot(1'b1, 2'h1, 1'b1);
        cyc(2);
        w = 16'($random(seed));
        @(negedge jclk);
        shift = 1'b1;
        // word lands in the model by step 17, then comes back on tdo
        for (int i = 0; i < 34; i++) begin
            @(negedge jclk);
            if (sclk) @(negedge jclk);
            tdi = (i < 16) ? w[15 - i] : 1'b0;
            chk(fsel_n, 1'b0);
            if (i == 17) begin
                for (int j = 0; j < 16; j++) chk(rx[j], w[j]);
            end
            if (i >= 18) chk(tdo, w[33 - i]);
            @(negedge jclk);
        end
        shift = 1'b0;
        repeat (6) @(negedge jclk);
        chk(fsel_n, 1'b1);
        chk(sclk, 1'b0);
        wrap_up();
    end
endmodule : test_config_error_restart_and_flash_loader
`default_nettype wire
